/* File: design/static_fwd_cfg.sv */
// static link forwarding configuration and per-link packet steering
// assumes link receivers and router on the same clock; register port
// is a plain strobe port, read data valid the cycle after the strobe
//
// Strobed register access was decided locally.
`default_nettype none
module static_fwd_cfg
	import static_fwd_pkg::*;
(
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic ce_i,
	// register port; address is the register index
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic [DATA_W-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [DATA_W-1:0] rdata_o,
	// incoming packet from a link, tagged with the link letter code
	input wire logic rx_valid_i,
	input wire logic [LINK_ID_W-1:0] rx_link_i,
	input wire logic [PKT_W-1:0] rx_data_i,
	// static path toward local processor and channel end
	output logic st_valid_o,
	output logic st_proc_o,
	output logic [CHAN_W-1:0] st_chan_o,
	output logic [PKT_W-1:0] st_data_o,
	// normal path into the router lookup
	output logic rt_valid_o,
	output logic [LINK_ID_W-1:0] rt_link_o,
	output logic [PKT_W-1:0] rt_data_o
);

	// configuration held per link letter code, stored fields only
	logic [NUM_LINKS-1:0] en_reg;
	logic [NUM_LINKS-1:0] proc_reg;
	logic [CHAN_W-1:0] chan_reg [NUM_LINKS];
	logic [DATA_W-1:0] rdata_reg;
	logic st_valid_reg;
	logic st_proc_reg;
	logic [CHAN_W-1:0] st_chan_reg;
	logic [PKT_W-1:0] st_data_reg;
	logic rt_valid_reg;
	logic [LINK_ID_W-1:0] rt_link_reg;
	logic [PKT_W-1:0] rt_data_reg;

	// register slot to link letter
	function automatic logic [2:0] slot_to_link(input logic [2:0] slot);
		case (slot)
			3'h0: slot_to_link = LINK_C;
			3'h1: slot_to_link = LINK_D;
			3'h2: slot_to_link = LINK_A;
			3'h3: slot_to_link = LINK_B;
			3'h4: slot_to_link = LINK_G;
			3'h5: slot_to_link = LINK_H;
			3'h6: slot_to_link = LINK_E;
			default: slot_to_link = LINK_F;
		endcase
	endfunction

	wire hit = (addr_i >= CFG_BASE_IDX) && (addr_i <= CFG_LAST_IDX);
	wire [ADDR_W-1:0] slot_full = addr_i - CFG_BASE_IDX;
	wire [2:0] sel_link = slot_to_link(slot_full[2:0]);
	wire [DATA_W-1:0] wmasked = wdata_i & CFG_WMASK;
	wire do_wr = ce_i && wr_i && hit;
	// reserved bits assembled as zero
	wire [DATA_W-1:0] cfg_view = {en_reg[sel_link], 22'h000000,
		proc_reg[sel_link], 3'h0, chan_reg[sel_link]};
	wire [DATA_W-1:0] rdata_next = hit ? cfg_view : UNMAPPED_READ;

	wire pkt_static = en_reg[rx_link_i];

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			en_reg <= '0;
			proc_reg <= '0;
			for (int i = 0; i < NUM_LINKS; i++) begin
				chan_reg[i] <= '0;
			end
		end else if (do_wr) begin
			en_reg[sel_link] <= wmasked[EN_BIT];
			proc_reg[sel_link] <= wmasked[PROC_BIT];
			chan_reg[sel_link] <= wmasked[CHAN_LSB +: CHAN_W];
		end
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			rdata_reg <= CFG_RESET;
		end else if (ce_i) begin
			rdata_reg <= rd_i ? rdata_next : CFG_RESET;
		end
	end

	// static traffic bypasses the router entirely
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			st_valid_reg <= 1'b0;
			rt_valid_reg <= 1'b0;
		end else if (ce_i) begin
			st_valid_reg <= rx_valid_i && pkt_static;
			rt_valid_reg <= rx_valid_i && !pkt_static;
		end
	end

	// payload and destination hold until the next packet, so a sink
	// that looks a cycle late still sees the last word
	wire take_pkt = ce_i && rx_valid_i;

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			st_proc_reg <= 1'b0;
			st_chan_reg <= '0;
			st_data_reg <= '0;
			rt_link_reg <= '0;
			rt_data_reg <= '0;
		end else if (take_pkt) begin
			st_proc_reg <= proc_reg[rx_link_i];
			st_chan_reg <= chan_reg[rx_link_i];
			st_data_reg <= rx_data_i;
			rt_link_reg <= rx_link_i;
			rt_data_reg <= rx_data_i;
		end
	end

	assign rdata_o = rdata_reg;
	assign st_valid_o = st_valid_reg;
	assign st_proc_o = st_proc_reg;
	assign st_chan_o = st_chan_reg;
	assign st_data_o = st_data_reg;
	assign rt_valid_o = rt_valid_reg;
	assign rt_link_o = rt_link_reg;
	assign rt_data_o = rt_data_reg;

	a_reset_clears_en: assert property (
		@(posedge clk_i)
		!nrst_i |=> en_reg == '0)
		else $error("enable not cleared by reset");
	a_reset_clears_proc: assert property (
		@(posedge clk_i)
		!nrst_i |=> proc_reg == '0)
		else $error("processor select not cleared by reset");
	a_en_write: assert property (
		@(posedge clk_i) disable iff (!nrst_i)
		do_wr |=> en_reg[$past(sel_link)] == $past(wdata_i[EN_BIT]))
		else $error("enable field not written");
	a_static_no_route: assert property (
		@(posedge clk_i) disable iff (!nrst_i)
		ce_i && rx_valid_i && en_reg[rx_link_i] |=>
		st_valid_o && !rt_valid_o)
		else $error("static packet not forwarded");
	a_static_data: assert property (
		@(posedge clk_i) disable iff (!nrst_i)
		ce_i && rx_valid_i && en_reg[rx_link_i] |=>
		st_data_o == $past(rx_data_i))
		else $error("static packet word wrong");
	a_idle_no_pulse: assert property (
		@(posedge clk_i) disable iff (!nrst_i)
		ce_i && !rx_valid_i |=> !st_valid_o && !rt_valid_o)
		else $error("packet pulse without a packet");
	a_normal_routes: assert property (
		@(posedge clk_i) disable iff (!nrst_i)
		ce_i && rx_valid_i && !en_reg[rx_link_i] |=>
		rt_valid_o && !st_valid_o)
		else $error("routed packet misdirected");
	a_route_payload: assert property (
		@(posedge clk_i) disable iff (!nrst_i)
		ce_i && rx_valid_i && !en_reg[rx_link_i] |=>
		rt_link_o == $past(rx_link_i) && rt_data_o == $past(rx_data_i))
		else $error("routed packet payload wrong");
	a_static_dest: assert property (
		@(posedge clk_i) disable iff (!nrst_i)
		ce_i && rx_valid_i && en_reg[rx_link_i] |=>
		st_chan_o == $past(chan_reg[rx_link_i]) &&
		st_proc_o == $past(proc_reg[rx_link_i]))
		else $error("static destination wrong");
	a_proc_write: assert property (
		@(posedge clk_i) disable iff (!nrst_i)
		do_wr |=> proc_reg[$past(sel_link)] == $past(wdata_i[PROC_BIT]))
		else $error("processor field not written");
	a_chan_write: assert property (
		@(posedge clk_i) disable iff (!nrst_i)
		do_wr |=>
		chan_reg[$past(sel_link)] == $past(wdata_i[CHAN_LSB +: CHAN_W]))
		else $error("channel field not written");
	a_slot_c_first: assert property (
		@(posedge clk_i) disable iff (!nrst_i)
		ce_i && wr_i && addr_i == CFG_BASE_IDX |=>
		en_reg[LINK_C] == $past(wdata_i[EN_BIT]))
		else $error("first slot is not link C");
	a_slot_f_last: assert property (
		@(posedge clk_i) disable iff (!nrst_i)
		ce_i && wr_i && addr_i == CFG_LAST_IDX |=>
		chan_reg[LINK_F] == $past(wdata_i[CHAN_LSB +: CHAN_W]))
		else $error("last slot is not link F");
	a_reserved_zero: assert property (
		@(posedge clk_i) disable iff (!nrst_i)
		ce_i && rd_i |=> (rdata_o & ~CFG_WMASK) == '0)
		else $error("reserved bits read nonzero");
	a_unmapped_zero: assert property (
		@(posedge clk_i) disable iff (!nrst_i)
		ce_i && rd_i && !hit |=> rdata_o == UNMAPPED_READ)
		else $error("unmapped read not zero");
	a_read_back: assert property (
		@(posedge clk_i) disable iff (!nrst_i)
		ce_i && wr_i && hit ##1 ce_i && rd_i && addr_i == $past(addr_i) |=>
		rdata_o == ($past(wdata_i, 2) & CFG_WMASK))
		else $error("readback mismatch");
	// clock enable low must freeze enables, processor selects, read data and both valid outputs
	a_frozen_state: assert property (
		@(posedge clk_i) disable iff (!nrst_i)
		!ce_i |=> $stable(en_reg) && $stable(proc_reg) &&
		$stable(rdata_o) && $stable(st_valid_o) && $stable(rt_valid_o))
		else $error("state moved while clock enable low");

	c_static_pkt: cover property (@(posedge clk_i) st_valid_o);
	c_routed_pkt: cover property (@(posedge clk_i) rt_valid_o);
	c_enable_then_pkt: cover property (@(posedge clk_i)
		do_wr && wdata_i[EN_BIT] ##[1:4] st_valid_o);
	c_read_hit: cover property (@(posedge clk_i) ce_i && rd_i && hit);
	c_frozen_write: cover property (@(posedge clk_i)
		!ce_i && wr_i && hit);

endmodule
`default_nettype wire

/* File: design/static_fwd_pkg.sv */
// constants for the static link forwarding configuration block
// assumes a single 40 MHz system clock domain
`default_nettype none
package static_fwd_pkg;
	localparam int NUM_LINKS = 8;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int CHAN_W = 5;
	localparam int LINK_ID_W = 3;
	localparam int PKT_W = 32;
	// register slots in order C, D, A, B, G, H, E, F
	localparam logic [ADDR_W-1:0] CFG_BASE_IDX = 8'hA0;
	localparam logic [ADDR_W-1:0] CFG_LAST_IDX = 8'hA7;
	// link letter codes A..H
	localparam logic [2:0] LINK_A = 3'h0;
	localparam logic [2:0] LINK_B = 3'h1;
	localparam logic [2:0] LINK_C = 3'h2;
	localparam logic [2:0] LINK_D = 3'h3;
	localparam logic [2:0] LINK_E = 3'h4;
	localparam logic [2:0] LINK_F = 3'h5;
	localparam logic [2:0] LINK_G = 3'h6;
	localparam logic [2:0] LINK_H = 3'h7;
	// field layout
	localparam int EN_BIT = 31;
	localparam int PROC_BIT = 8;
	localparam int CHAN_LSB = 0;
	localparam logic [DATA_W-1:0] CFG_WMASK = 32'h8000_011F;
	localparam logic [DATA_W-1:0] CFG_RESET = 32'h0000_0000;
	localparam logic [DATA_W-1:0] UNMAPPED_READ = 32'h0000_0000;
endpackage
`default_nettype wire

/* File: test/fwd_sink.sv */
// sink model standing for local processors and the router input
// assumes one packet word per valid pulse and no back-pressure
`default_nettype none
module fwd_sink (
	input wire logic clk_i,
	input wire logic st_valid_i,
	input wire logic st_proc_i,
	input wire logic [4:0] st_chan_i,
	input wire logic [31:0] st_data_i,
	input wire logic rt_valid_i,
	input wire logic [2:0] rt_link_i,
	input wire logic [31:0] rt_data_i,
	output logic [1:0] kind_o,
	output logic [37:0] word_o
);
	timeunit 1ns;
	timeprecision 100ps;
	// keeps the last packet so the bench can look after the pulse
	always @(posedge clk_i) begin
		if (st_valid_i) begin
			kind_o <= 2'b10;
			word_o <= {st_proc_i, st_chan_i, st_data_i};
		end else if (rt_valid_i) begin
			kind_o <= 2'b01;
			word_o <= {3'h0, rt_link_i, rt_data_i};
		end
	end
endmodule
`default_nettype wire

/* File: test/tb.sv */
// bench for static_fwd_cfg: registers, slot order, packet steering
// assumes only the block and the sink model, one 40 MHz clock
`default_nettype none
module tb
	import static_fwd_pkg::*;
();
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_i = 0, nrst_i = 0, ce_i = 1, wr_i = 0, rd_i = 0, rx_valid_i = 0;
	logic [7:0] addr_i = '0;
	logic [31:0] wdata_i = '0, rx_data_i = '0, seed = 32'hDFFDD922, d;
	logic [2:0] rx_link_i = '0;
	wire logic [31:0] rdata_o, st_data_o, rt_data_o;
	wire logic st_valid_o, st_proc_o, rt_valid_o;
	wire logic [4:0] st_chan_o;
	wire logic [2:0] rt_link_o;
	wire logic [1:0] kind;
	wire logic [37:0] word;
	int n_fail = 0, samples_checked = 0;
	logic [31:0] cfg [8];
	static_fwd_cfg DUT (.clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce_i),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
		.rdata_o(rdata_o), .rx_valid_i(rx_valid_i), .rx_link_i(rx_link_i),
		.rx_data_i(rx_data_i), .st_valid_o(st_valid_o), .st_proc_o(st_proc_o),
		.st_chan_o(st_chan_o), .st_data_o(st_data_o), .rt_valid_o(rt_valid_o),
		.rt_link_o(rt_link_o), .rt_data_o(rt_data_o));
	fwd_sink sink (.clk_i(clk_i), .st_valid_i(st_valid_o), .st_proc_i(st_proc_o),
		.st_chan_i(st_chan_o), .st_data_i(st_data_o), .rt_valid_i(rt_valid_o),
		.rt_link_i(rt_link_o), .rt_data_i(rt_data_o), .kind_o(kind), .word_o(word));
	initial forever #12.5 clk_i = ~clk_i;
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// slots run C, D, A, B, G, H, E, F: slot index is link code xor 2
	function automatic logic [39:0] expect_of(input logic [2:0] l,
		input logic [31:0] w);
		logic [31:0] c;
		c = cfg[l ^ 3'h2];
		if (c[31]) return {2'b10, c[8], c[4:0], w};
		return {2'b01, 3'h0, l, w};
	endfunction
	task automatic chk(input logic [39:0] g, input logic [39:0] e);
		samples_checked++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic stop_test();
		$display("n_fail %0d samples_checked %0d", n_fail, samples_checked);
		if (n_fail == 0 && samples_checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= v;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask
	// write then read the same slot back to back, no idle cycle
	task automatic wrrd(input logic [7:0] a, input logic [31:0] v,
		input logic [31:0] e);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= v;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 chk({8'h0, rdata_o}, {8'h0, e});
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 chk({8'h0, rdata_o}, {8'h0, e});
	endtask
	task automatic pkt(input logic [2:0] l, input logic [31:0] w);
		@(posedge clk_i);
		rx_valid_i <= 1'b1;
		rx_link_i <= l;
		rx_data_i <= w;
		@(posedge clk_i);
		rx_valid_i <= 1'b0;
		@(posedge clk_i);
		#1 chk({kind, word}, expect_of(l, w));
	endtask
	initial begin
		#100000 n_fail++;
		stop_test();
	end
	initial begin
		repeat (6) @(posedge clk_i);
		nrst_i <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			rd(8'(8'hA0 + i), 32'h0);
		end
		for (int i = 0; i < 8; i++) begin
			cfg[i] = (i == 0) ? 32'hFFFF_FFFF : rnd();
			wrrd(8'(8'hA0 + i), cfg[i], cfg[i] & 32'h8000_011F);
			cfg[i] &= 32'h8000_011F;
		end
		for (int i = 0; i < 8; i++) rd(8'(8'hA0 + i), cfg[i]);
		// a write while the clock enable is low must leave slot C alone
		@(posedge clk_i);
		ce_i <= 1'b0;
		wr(8'hA0, 32'h0);
		ce_i <= 1'b1;
		rd(8'hA0, cfg[0]);
		wr(8'hA8, 32'hFFFF_FFFF);
		rd(8'hA8, 32'h0);
		rd(8'h9F, 32'h0);
		// past-the-end index matches slot C in its low bits but must not write it
		wr(8'hA8, 32'h0);
		rd(8'hA0, cfg[0]);
		// two passes with every enable flipped, so each link sees both paths
		for (int p = 0; p < 2; p++) begin
			for (int l = 0; l < 8; l++) begin
				d = rnd();
				pkt(3'(l), d);
			end
			for (int i = 0; i < 8; i++) begin
				cfg[i] ^= 32'h8000_0000;
				wr(8'(8'hA0 + i), cfg[i]);
			end
		end
		// mid-run reset must drop every link back to routed mode
		@(posedge clk_i);
		nrst_i <= 1'b0;
		@(posedge clk_i);
		nrst_i <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			cfg[i] = '0;
			rd(8'(8'hA0 + i), 32'h0);
		end
		d = rnd();
		pkt(d[2:0], d);
		stop_test();
	end
endmodule
`default_nettype wire
